// *** src/quiro_pkg.sv ***
// Shared constants for the quad UART interrupt and ready output logic
`default_nettype none
package quiro_pkg;
  localparam int       NUM_CHAN       = 4;
  localparam int       MCR_WIDTH      = 8;
  localparam int       MCR_IRQ_EN_BIT = 3;
  localparam int       SYNC_STAGES    = 2;
  localparam int       CHAN_A         = 0;
  localparam int       CHAN_B         = 1;
  localparam int       CHAN_C         = 2;
  localparam int       CHAN_D         = 3;
  localparam logic     MODE_SEPARATE  = 1'h1;
  localparam logic     MODE_RW_LINE   = 1'h0;
  localparam logic     SELECT_ACTIVE  = 1'h0;
  localparam logic     READY_IDLE_N   = 1'h1;
  localparam logic     IRQ_IDLE_LEVEL = 1'h0;
  localparam logic     OVERRIDE_TIED  = 1'h1;
  localparam logic     PIN_ZERO       = 1'h0;
  localparam logic     PIN_DRIVEN     = 1'h1;
  localparam logic     PIN_FLOAT      = 1'h0;
endpackage
`default_nettype wire

// *** src/quiro_sync2.sv ***
// Two-flop synchroniser for asynchronous pin inputs
`default_nettype none
module quiro_sync2
  import quiro_pkg::*;
#(
  parameter int   WIDTH      = 1,
  parameter logic RESET_LVL  = 1'h0
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  ////////////////////////////////////////////////////////////////////////////
  // First stage feeds only the second stage
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stage1   <= {WIDTH{RESET_LVL}};
      sync_out <= {WIDTH{RESET_LVL}};
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule // quiro_sync2
`default_nettype wire

// *** src/quiro_ready_out.sv ***
// Registered active-low per-channel and combined ready outputs
`default_nettype none
module quiro_ready_out
  import quiro_pkg::*;
#(
  parameter int CHANNELS = NUM_CHAN
) (
  input  wire logic                clk_sys,
  input  wire logic                rst,
  input  wire logic [CHANNELS-1:0] ready_in,
  output var  logic [CHANNELS-1:0] ready_n,
  output var  logic                any_ready_n
);
  ////////////////////////////////////////////////////////////////////////////
  // Per-channel status, inverted to the active-low pin sense
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ready_n <= {CHANNELS{READY_IDLE_N}};
    end else begin
      ready_n <= ~ready_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wired-OR of active-low lines: low when any channel is ready
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      any_ready_n <= READY_IDLE_N;
    end else begin
      any_ready_n <= ~(|ready_in);
    end
  end
endmodule // quiro_ready_out
`default_nettype wire

// *** src/quiro_top.sv ***
// Interrupt pins, channel D select and ready outputs of a four-channel UART
`default_nettype none
//
// Contract
// - Separate-strobe mode: channel D select pin, active low, enables channel D.
// - Read/write-line mode: channel D select pin is ignored entirely.
// - Separate-strobe mode: first interrupt pin carries channel A interrupt only.
// - Separate-strobe mode: pin driven when its modem control bit 3 set or override high, else floats.
// - Read/write-line mode: first pin is device interrupt, active low, open drain.
// - Read/write-line mode: interrupt pins of channels B, C, D held at zero.
// - Separate-strobe mode: override input high enables all interrupt pins continuously.
// - Separate-strobe mode, override low: each channel's modem control bit 3 decides pin enable.
// - Variant without override pin behaves as though it were tied high.
// - Each channel has an active-low transmit-ready output from its status.
// - Each channel has an active-low receive-ready output from its status.
// - Combined transmit and receive ready outputs wire-OR the four channels.
module quiro_top
  import quiro_pkg::*;
#(
  parameter bit HAS_IRQ_SELECT_PIN = 1'b1
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  input  wire logic                 bus_mode_sel,
  input  wire logic                 chan_d_select_n,
  input  wire logic                 irq_enable_override,
  input  wire logic [MCR_WIDTH-1:0] modem_control_reg_a,
  input  wire logic [MCR_WIDTH-1:0] modem_control_reg_b,
  input  wire logic [MCR_WIDTH-1:0] modem_control_reg_c,
  input  wire logic [MCR_WIDTH-1:0] modem_control_reg_d,
  input  wire logic                 chan_a_irq_pending,
  input  wire logic                 chan_b_irq_pending,
  input  wire logic                 chan_c_irq_pending,
  input  wire logic                 chan_d_irq_pending,
  input  wire logic                 chan_a_tx_status,
  input  wire logic                 chan_b_tx_status,
  input  wire logic                 chan_c_tx_status,
  input  wire logic                 chan_d_tx_status,
  input  wire logic                 chan_a_rx_status,
  input  wire logic                 chan_b_rx_status,
  input  wire logic                 chan_c_rx_status,
  input  wire logic                 chan_d_rx_status,
  output var  logic                 chan_d_access_en,
  output var  logic                 chan_a_irq_out,
  output var  logic                 chan_a_irq_out_oe,
  output var  logic                 chan_b_irq_out,
  output var  logic                 chan_b_irq_out_oe,
  output var  logic                 chan_c_irq_out,
  output var  logic                 chan_c_irq_out_oe,
  output var  logic                 chan_d_irq_out,
  output var  logic                 chan_d_irq_out_oe,
  output var  logic                 chan_a_tx_ready_n,
  output var  logic                 chan_b_tx_ready_n,
  output var  logic                 chan_c_tx_ready_n,
  output var  logic                 chan_d_tx_ready_n,
  output var  logic                 chan_a_rx_ready_n,
  output var  logic                 chan_b_rx_ready_n,
  output var  logic                 chan_c_rx_ready_n,
  output var  logic                 chan_d_rx_ready_n,
  output var  logic                 any_tx_ready_n,
  output var  logic                 any_rx_ready_n
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [MCR_WIDTH-1:0] modem_control_reg [NUM_CHAN];
  logic [NUM_CHAN-1:0]  pending;
  logic [NUM_CHAN-1:0]  tx_status;
  logic [NUM_CHAN-1:0]  rx_status;
  logic [NUM_CHAN-1:0]  tx_ready_n;
  logic [NUM_CHAN-1:0]  rx_ready_n;
  logic [NUM_CHAN-1:0]  next_irq_en;
  logic [NUM_CHAN-1:0]  irq_out;
  logic [NUM_CHAN-1:0]  irq_oe;
  logic [2:0]           pins_sync;
  logic                 mode_sep;
  logic                 csd_n_sync;
  logic                 ovr_sync;
  logic                 ovr_eff;
  logic                 next_chan_d_en;
  logic [1:0]           flush_cnt;
  logic                 mode_known;

  function automatic logic irq_pin_enable(input logic ovr,
                                          input logic [MCR_WIDTH-1:0] mcr_val);
    irq_pin_enable = ovr | mcr_val[MCR_IRQ_EN_BIT];
  endfunction

  assign modem_control_reg[CHAN_A]    = modem_control_reg_a;
  assign modem_control_reg[CHAN_B]    = modem_control_reg_b;
  assign modem_control_reg[CHAN_C]    = modem_control_reg_c;
  assign modem_control_reg[CHAN_D]    = modem_control_reg_d;
  assign pending        = {chan_d_irq_pending, chan_c_irq_pending,
                           chan_b_irq_pending, chan_a_irq_pending};
  assign tx_status      = {chan_d_tx_status, chan_c_tx_status,
                           chan_b_tx_status, chan_a_tx_status};
  assign rx_status      = {chan_d_rx_status, chan_c_rx_status,
                           chan_b_rx_status, chan_a_rx_status};

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; the select idles deasserted so reset never opens D
  quiro_sync2 #(
    .WIDTH     (3),
    .RESET_LVL (1'h0)
  ) u_sync_mode_ovr (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .async_in ({bus_mode_sel, ~chan_d_select_n, irq_enable_override}),
    .sync_out (pins_sync)
  );

  assign mode_sep   = pins_sync[2];
  assign csd_n_sync = ~pins_sync[1];
  assign ovr_sync   = pins_sync[0];

  ////////////////////////////////////////////////////////////////////////////
  // Flush count: the synchronised mode is trusted only once both stages
  // have loaded since reset; until then the mode bit shows its reset level,
  // which would drive the channel B..D pins in the wrong mode
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      flush_cnt <= 2'h0;
    end else if (!mode_known) begin
      flush_cnt <= flush_cnt + 2'h1;
    end
  end

  assign mode_known = (flush_cnt == 2'(SYNC_STAGES));

  ////////////////////////////////////////////////////////////////////////////
  // Channel D select
  assign next_chan_d_en = (mode_sep == MODE_SEPARATE) && (csd_n_sync == SELECT_ACTIVE);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      chan_d_access_en <= 1'h0;
    end else begin
      chan_d_access_en <= next_chan_d_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt enables; a part without the override pin runs as if tied high
  assign ovr_eff = HAS_IRQ_SELECT_PIN ? ovr_sync : OVERRIDE_TIED;

  // Override is only honoured in separate-strobe mode, where the system may drive it
  generate
    for (genvar ch = 0; ch < NUM_CHAN; ch++) begin : g_irq_en
      assign next_irq_en[ch] = irq_pin_enable(ovr_eff, modem_control_reg[ch]);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt pins; outputs float from reset until the mode is known
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_out <= {NUM_CHAN{IRQ_IDLE_LEVEL}};
      irq_oe  <= {NUM_CHAN{PIN_FLOAT}};
    end else if (!mode_known) begin
      irq_out <= {NUM_CHAN{IRQ_IDLE_LEVEL}};
      irq_oe  <= {NUM_CHAN{PIN_FLOAT}};
    end else if (mode_sep == MODE_SEPARATE) begin
      irq_out <= pending;
      irq_oe  <= next_irq_en;
    end else begin
      irq_out          <= {NUM_CHAN{PIN_ZERO}};
      irq_oe           <= {NUM_CHAN{PIN_DRIVEN}};
      irq_oe[CHAN_A]   <= |pending;
    end
  end

  assign chan_a_irq_out    = irq_out[CHAN_A];
  assign chan_a_irq_out_oe = irq_oe[CHAN_A];
  assign chan_b_irq_out    = irq_out[CHAN_B];
  assign chan_b_irq_out_oe = irq_oe[CHAN_B];
  assign chan_c_irq_out    = irq_out[CHAN_C];
  assign chan_c_irq_out_oe = irq_oe[CHAN_C];
  assign chan_d_irq_out    = irq_out[CHAN_D];
  assign chan_d_irq_out_oe = irq_oe[CHAN_D];

  ////////////////////////////////////////////////////////////////////////////
  // Ready outputs; status arrives from logic on this clock, so no synchroniser
  quiro_ready_out #(
    .CHANNELS (NUM_CHAN)
  ) u_tx_ready (
    .clk_sys     (clk_sys),
    .rst         (rst),
    .ready_in    (tx_status),
    .ready_n     (tx_ready_n),
    .any_ready_n (any_tx_ready_n)
  );

  quiro_ready_out #(
    .CHANNELS (NUM_CHAN)
  ) u_rx_ready (
    .clk_sys     (clk_sys),
    .rst         (rst),
    .ready_in    (rx_status),
    .ready_n     (rx_ready_n),
    .any_ready_n (any_rx_ready_n)
  );

  assign chan_a_tx_ready_n = tx_ready_n[CHAN_A];
  assign chan_b_tx_ready_n = tx_ready_n[CHAN_B];
  assign chan_c_tx_ready_n = tx_ready_n[CHAN_C];
  assign chan_d_tx_ready_n = tx_ready_n[CHAN_D];
  assign chan_a_rx_ready_n = rx_ready_n[CHAN_A];
  assign chan_b_rx_ready_n = rx_ready_n[CHAN_B];
  assign chan_c_rx_ready_n = rx_ready_n[CHAN_C];
  assign chan_d_rx_ready_n = rx_ready_n[CHAN_D];

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  // Interrupt antecedents skip the reset edge and the flush window; a_reset_idle and a_pin_float_flush check those
  a_reset_idle: assert property (@(posedge clk_sys)
    rst |=> (!chan_d_access_en && (irq_oe == {NUM_CHAN{PIN_FLOAT}}) && (&tx_ready_n) &&
             (&rx_ready_n) && any_tx_ready_n && any_rx_ready_n))
    else $error("outputs not idle after reset");

  a_chan_d_select: assert property (@(posedge clk_sys) disable iff (rst)
    (!rst && mode_sep && !csd_n_sync) |=> chan_d_access_en)
    else $error("channel D select not honoured");

  a_chan_d_release: assert property (@(posedge clk_sys) disable iff (rst)
    (!rst && !(mode_sep && !csd_n_sync)) |=> !chan_d_access_en)
    else $error("channel D open without its select");

  a_chan_d_ignored: assert property (@(posedge clk_sys) disable iff (rst)
    !mode_sep |=> !chan_d_access_en)
    else $error("channel D select active in read/write-line mode");

  a_irq_a_follows: assert property (@(posedge clk_sys) disable iff (rst)
    (!rst && mode_known && mode_sep) |=> (chan_a_irq_out == $past(chan_a_irq_pending)))
    else $error("channel A interrupt pin does not follow channel A");

  a_irq_levels_sep: assert property (@(posedge clk_sys) disable iff (rst)
    (!rst && mode_known && mode_sep) |=> (irq_out == $past(pending)))
    else $error("channel interrupt levels do not follow pending");

  a_irq_mcr_gate: assert property (@(posedge clk_sys) disable iff (rst)
    (!rst && mode_known && mode_sep && !ovr_eff) |=>
      (irq_oe == $past({modem_control_reg[CHAN_D][MCR_IRQ_EN_BIT], modem_control_reg[CHAN_C][MCR_IRQ_EN_BIT],
                        modem_control_reg[CHAN_B][MCR_IRQ_EN_BIT], modem_control_reg[CHAN_A][MCR_IRQ_EN_BIT]})))
    else $error("interrupt enable does not track modem control bit");

  a_pin_float_flush: assert property (@(posedge clk_sys) disable iff (rst)
    (!rst && !mode_known) |=> (irq_oe == {NUM_CHAN{PIN_FLOAT}}))
    else $error("interrupt pins driven before the mode is known");

  a_flush_bounded: assert property (@(posedge clk_sys) disable iff (rst)
    flush_cnt <= 2'(SYNC_STAGES))
    else $error("flush count ran past the synchroniser depth");

  a_irq_od_device: assert property (@(posedge clk_sys) disable iff (rst)
    (!rst && mode_known && !mode_sep) |=>
      (!chan_a_irq_out && (chan_a_irq_out_oe == $past(|pending))))
    else $error("device interrupt not open drain active low");

  a_rw_released: assert property (@(posedge clk_sys) disable iff (rst)
    (!rst && mode_known && !mode_sep && !(|pending)) |=> !chan_a_irq_out_oe)
    else $error("device interrupt pulled low with nothing pending");

  a_irq_bcd_zero: assert property (@(posedge clk_sys) disable iff (rst)
    (!rst && mode_known && !mode_sep) |=>
      (irq_oe[CHAN_D:CHAN_B] == 3'h7 && irq_out[CHAN_D:CHAN_B] == 3'h0))
    else $error("unused interrupt pins not held at zero");

  a_override_all: assert property (@(posedge clk_sys) disable iff (rst)
    (!rst && mode_known && mode_sep && ovr_eff) |=> (irq_oe == {NUM_CHAN{PIN_DRIVEN}}))
    else $error("override did not enable all interrupt pins");

  a_no_pin_tied: assert property (@(posedge clk_sys) disable iff (rst)
    (!rst && mode_known && !HAS_IRQ_SELECT_PIN && mode_sep) |=>
      (irq_oe == {NUM_CHAN{PIN_DRIVEN}}))
    else $error("pinless variant not continuously enabled");

  a_ready_tx_map: assert property (@(posedge clk_sys) disable iff (rst)
    !rst |=> ((tx_ready_n == ~$past(tx_status)) && (any_tx_ready_n == !$past(|tx_status))))
    else $error("transmit ready outputs mismatch");

  a_ready_rx_map: assert property (@(posedge clk_sys) disable iff (rst)
    !rst |=> ((rx_ready_n == ~$past(rx_status)) && (any_rx_ready_n == !$past(|rx_status))))
    else $error("receive ready outputs mismatch");

  a_ready_wired_or: assert property (@(posedge clk_sys) disable iff (rst)
    (any_tx_ready_n == (&tx_ready_n)) && (any_rx_ready_n == (&rx_ready_n)))
    else $error("combined ready outputs disagree with channel outputs");

  c_select_d: cover property (@(posedge clk_sys) disable iff (rst)
    mode_sep && !csd_n_sync ##1 chan_d_access_en);

  c_rw_irq: cover property (@(posedge clk_sys) disable iff (rst)
    !mode_sep ##1 chan_a_irq_out_oe);

  c_override: cover property (@(posedge clk_sys) disable iff (rst)
    mode_sep && ovr_eff && !modem_control_reg[CHAN_B][MCR_IRQ_EN_BIT] ##1 chan_b_irq_out_oe);

  c_all_ready: cover property (@(posedge clk_sys) disable iff (rst)
    (&tx_status) ##1 !any_tx_ready_n);

  c_flush_done: cover property (@(posedge clk_sys) disable iff (rst)
    !mode_known ##1 mode_known);

endmodule // quiro_top
`default_nettype wire

// *** bench/quiro_host_model.sv ***
// Host side board model: resolves interrupt pin levels seen by the processor
`default_nettype none
module quiro_host_model
  import quiro_pkg::*;
(
  input  wire logic [NUM_CHAN-1:0] irq_out,
  input  wire logic [NUM_CHAN-1:0] irq_oe,
  input  wire logic                host_req,
  input  wire logic [1:0]          host_chan,
  output var  logic [NUM_CHAN-1:0] irq_wire,
  output var  logic [NUM_CHAN-1:0] select_n
);
  timeunit 1ns;
  timeprecision 100ps;
  // Board pull-ups: a floating pin reads high, so open-drain low is visible
  always_comb begin
    for (int i = 0; i < NUM_CHAN; i++) begin
      irq_wire[i] = irq_oe[i] ? irq_out[i] : 1'h1;
      // Host decodes one active-low select per channel, only one low at a time
      select_n[i] = !(host_req && (int'(host_chan) == i));
    end
  end
endmodule // quiro_host_model
`default_nettype wire

// *** bench/quiro_top_bench.sv ***
// Self-checking bench for the interrupt, select and ready outputs
`default_nettype none
module quiro_top_bench;
  import quiro_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic                 clk_sys, rst, mode, host_req, ovr, acc, any_tx_n, any_rx_n;
  logic [1:0]           host_chan;
  logic [MCR_WIDTH-1:0] mcr_a, mcr_b, mcr_c, mcr_d;
  logic [3:0]           pend, txs, rxs, iq, oe, txr_n, rxr_n, wire_lvl, sel_all, oe_np;
  int                   n_mismatch, n_checks;
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'h0;
    forever #4 clk_sys = ~clk_sys;
  end
  quiro_top i_quiro_top (
    .clk_sys(clk_sys), .rst(rst), .bus_mode_sel(mode), .chan_d_select_n(sel_all[3]),
    .irq_enable_override(ovr), .modem_control_reg_a(mcr_a),
    .modem_control_reg_b(mcr_b), .modem_control_reg_c(mcr_c),
    .modem_control_reg_d(mcr_d), .chan_a_irq_pending(pend[0]),
    .chan_b_irq_pending(pend[1]), .chan_c_irq_pending(pend[2]),
    .chan_d_irq_pending(pend[3]), .chan_a_tx_status(txs[0]), .chan_b_tx_status(txs[1]),
    .chan_c_tx_status(txs[2]), .chan_d_tx_status(txs[3]), .chan_a_rx_status(rxs[0]),
    .chan_b_rx_status(rxs[1]), .chan_c_rx_status(rxs[2]), .chan_d_rx_status(rxs[3]),
    .chan_d_access_en(acc), .chan_a_irq_out(iq[0]), .chan_a_irq_out_oe(oe[0]),
    .chan_b_irq_out(iq[1]), .chan_b_irq_out_oe(oe[1]), .chan_c_irq_out(iq[2]),
    .chan_c_irq_out_oe(oe[2]), .chan_d_irq_out(iq[3]), .chan_d_irq_out_oe(oe[3]),
    .chan_a_tx_ready_n(txr_n[0]), .chan_b_tx_ready_n(txr_n[1]),
    .chan_c_tx_ready_n(txr_n[2]), .chan_d_tx_ready_n(txr_n[3]),
    .chan_a_rx_ready_n(rxr_n[0]), .chan_b_rx_ready_n(rxr_n[1]),
    .chan_c_rx_ready_n(rxr_n[2]), .chan_d_rx_ready_n(rxr_n[3]),
    .any_tx_ready_n(any_tx_n), .any_rx_ready_n(any_rx_n)
  );
  quiro_host_model i_quiro_host_model (
    .irq_out(iq), .irq_oe(oe), .irq_wire(wire_lvl),
    .host_req(host_req), .host_chan(host_chan), .select_n(sel_all)
  );
  // Variant without the override pin; only its interrupt enables are compared
  quiro_top #(.HAS_IRQ_SELECT_PIN(1'b0)) i_quiro_top_nopin (
    .clk_sys(clk_sys), .rst(rst), .bus_mode_sel(mode), .chan_d_select_n(sel_all[3]),
    .irq_enable_override(ovr), .modem_control_reg_a(mcr_a),
    .modem_control_reg_b(mcr_b), .modem_control_reg_c(mcr_c),
    .modem_control_reg_d(mcr_d), .chan_a_irq_pending(pend[0]),
    .chan_b_irq_pending(pend[1]), .chan_c_irq_pending(pend[2]),
    .chan_d_irq_pending(pend[3]), .chan_a_tx_status(txs[0]), .chan_b_tx_status(txs[1]),
    .chan_c_tx_status(txs[2]), .chan_d_tx_status(txs[3]), .chan_a_rx_status(rxs[0]),
    .chan_b_rx_status(rxs[1]), .chan_c_rx_status(rxs[2]), .chan_d_rx_status(rxs[3]),
    .chan_d_access_en(), .chan_a_irq_out(), .chan_a_irq_out_oe(oe_np[0]),
    .chan_b_irq_out(), .chan_b_irq_out_oe(oe_np[1]), .chan_c_irq_out(),
    .chan_c_irq_out_oe(oe_np[2]), .chan_d_irq_out(), .chan_d_irq_out_oe(oe_np[3]),
    .chan_a_tx_ready_n(), .chan_b_tx_ready_n(), .chan_c_tx_ready_n(), .chan_d_tx_ready_n(),
    .chan_a_rx_ready_n(), .chan_b_rx_ready_n(), .chan_c_rx_ready_n(), .chan_d_rx_ready_n(),
    .any_tx_ready_n(), .any_rx_ready_n()
  );
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  // Pins pass two synchroniser stages and an output flop, so four edges settle all
  task automatic settle();
    repeat (4) @(posedge clk_sys);
    #1;
  endtask
  task automatic final_report();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    n_mismatch = 0;
    n_checks = 0;
    rst = 1'h1;
    mode = MODE_SEPARATE;
    host_req = 1'h0;
    host_chan = 2'h0;
    ovr = 1'h0;
    {mcr_a, mcr_b, mcr_c, mcr_d} = '0;
    {pend, txs, rxs} = '0;
    repeat (3) @(posedge clk_sys);
    rst <= 1'h0;
    settle();
    chk({iq, oe}, 8'h00);
    chk({4'h0, oe_np}, 8'h0F);
    // Separate mode: each pin enable follows its own bit 3, level follows pending
    for (int k = 0; k < 16; k++) begin
      @(posedge clk_sys);
      mcr_a <= k[0] ? 8'h08 : 8'hF7;
      mcr_b <= k[1] ? 8'h08 : 8'hF7;
      mcr_c <= k[2] ? 8'h08 : 8'hF7;
      mcr_d <= k[3] ? 8'h08 : 8'hF7;
      pend  <= {k[0], k[3:1]};
      settle();
      chk({4'h0, oe}, {4'h0, k[3:0]});
      chk({4'h0, iq}, {4'h0, k[0], k[3:1]});
      chk({4'h0, wire_lvl}, {4'h0, ~k[3:0] | {k[0], k[3:1]}});
    end
    // Override forces every pin enabled even with all enable bits clear
    @(posedge clk_sys);
    {mcr_a, mcr_b, mcr_c, mcr_d} <= '0;
    ovr <= 1'h1;
    settle();
    chk({4'h0, oe}, 8'h0F);
    // Channel D select, active low, only in separate mode
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_sys);
      host_req  <= 1'h1;
      host_chan <= k[0] ? 2'(CHAN_A) : 2'(CHAN_D);
      settle();
      chk({7'h0, acc}, {7'h0, ~k[0]});
      chk({7'h0, sel_all[0]}, {7'h0, ~k[0]});
    end
    // Read/write-line mode with override held low by the system
    @(posedge clk_sys);
    ovr <= 1'h0;
    mode <= MODE_RW_LINE;
    host_chan <= 2'(CHAN_D);
    settle();
    chk({7'h0, acc}, 8'h00);
    for (int k = 0; k < 16; k++) begin
      @(posedge clk_sys);
      pend <= k[3:0];
      {mcr_a, mcr_b, mcr_c, mcr_d} <= '0;
      settle();
      chk({7'h0, wire_lvl[0]}, {7'h0, ~(|k[3:0])});
      chk({7'h0, iq[0]}, 8'h00);
      chk({1'h0, iq[3:1], 1'h0, oe[3:1]}, 8'h07);
    end
    // Ready outputs: every status pattern, per channel and combined
    for (int k = 0; k < 16; k++) begin
      @(posedge clk_sys);
      txs <= k[3:0];
      rxs <= ~k[3:0];
      repeat (2) @(posedge clk_sys);
      #1;
      chk({4'h0, txr_n}, {4'h0, ~k[3:0]});
      chk({4'h0, rxr_n}, {4'h0, k[3:0]});
      chk({6'h0, any_tx_n, any_rx_n}, {6'h0, ~(|k[3:0]), ~(|(~k[3:0]))});
    end
    // Mid-run reset: idle outputs, and pins float until the mode is known again
    @(posedge clk_sys);
    mode      <= MODE_SEPARATE;
    ovr       <= 1'h1;
    host_chan <= 2'(CHAN_D);
    settle();
    chk({7'h0, acc}, 8'h01);
    @(posedge clk_sys);
    rst <= 1'h1;
    repeat (2) @(posedge clk_sys);
    #1;
    chk({iq, oe}, 8'h00);
    chk({txr_n, rxr_n}, 8'hFF);
    chk({5'h0, acc, any_tx_n, any_rx_n}, 8'h03);
    @(posedge clk_sys);
    rst <= 1'h0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk({acc, 3'h0, oe}, 8'h00);
    @(posedge clk_sys);
    #1;
    chk({acc, 3'h0, oe}, 8'h8F);
    final_report();
  end
endmodule // quiro_top_bench
`default_nettype wire
